// ==== src/sld_latch_driver.sv ====
`timescale 1ns/1ns

module sld_latch_driver
   import sld_pkg::*;
(
   // System clock and reset
   input  wire logic        clk_sys_in,
   input  wire logic        rst_in,
   // Serial link from the host, clocked by the host
   input  wire logic        shift_clk_in,
   input  wire logic        serial_in,
   output logic             serial_out_out,
   // Control pins, asynchronous to both clocks
   input  wire logic        latch_strobe_in,
   input  wire logic        latch_strobe_driven_in,
   input  wire logic        out_en_n_in,
   input  wire logic        out_en_n_driven_in,
   // Local flow control
   input  wire logic        update_hold_in,
   // Sink drive and status
   output logic [15:0]      sink_channels_out,
   output logic             busy_out,
   output logic             overrun_out
);

   ////////////////////////////////////////////////////////////////////////////
   // Link domain: shift register on the host's clock

   logic [15:0] shift_q;       // Shift stages, bit 0 newest
   logic [15:0] snap_q;        // Copy of stages held stable for the crossing
   logic        snap_tgl_q;    // Flips once per shift edge

   // New bit enters stage 0 and every stage moves one place toward the output;
   // shared by the stages and the snapshot so the two can never disagree
   function automatic logic [15:0] sld_shift_in(input logic [15:0] w, input logic b);
      return {w[14:0], b};
   endfunction

   // Shift one place, new bit into stage 0
   always_ff @(posedge shift_clk_in or posedge rst_in) begin
      if (rst_in) begin
         shift_q <= SLD_WORD_RST;
      end else begin
         shift_q <= sld_shift_in(shift_q, serial_in);
      end
   end

   // Snapshot stays put for a whole link period, far longer than the sync delay;
   // a toggle rather than a pulse, so no edge is lost while the link stays within SLD_SHIFT_MAX_MHZ
   always_ff @(posedge shift_clk_in or posedge rst_in) begin
      if (rst_in) begin
         snap_q     <= SLD_WORD_RST;
         snap_tgl_q <= 1'b0;
      end else begin
         snap_q     <= sld_shift_in(shift_q, serial_in);
         snap_tgl_q <= ~snap_tgl_q;
      end
   end

   // Cascade output straight off the last stage
   assign serial_out_out = shift_q[SLD_LAST_STAGE];

   ////////////////////////////////////////////////////////////////////////////
   // Crossing of the shift event into the system domain

   logic tgl_s1_q;             // First synchroniser flop
   logic tgl_s2_q;             // Second synchroniser flop
   logic tgl_s3_q;             // Delayed copy for edge detection
   logic shift_evt;            // One system cycle per link edge

   // Toggle synchroniser; only the second and third flops are examined
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         tgl_s1_q <= 1'b0;
         tgl_s2_q <= 1'b0;
         tgl_s3_q <= 1'b0;
      end else begin
         tgl_s1_q <= snap_tgl_q;
         tgl_s2_q <= tgl_s1_q;
         tgl_s3_q <= tgl_s2_q;
      end
   end

   // The event reaches the buffer two to three system cycles after the shift
   // edge; the snapshot word has stood still since that edge, so it is taken
   // whole without a gray code
   assign shift_evt = tgl_s2_q ^ tgl_s3_q;

   ////////////////////////////////////////////////////////////////////////////
   // Snapshot buffer between the crossing and the latch

   logic        fifo_in_ready;   // Buffer can take a snapshot
   logic        fifo_out_valid;  // Buffer holds a snapshot
   logic        fifo_out_ready;  // Drain side takes one
   logic [15:0] fifo_out_data;   // Oldest snapshot

   sld_fifo #(
      .WIDTH (SLD_WORD_W),
      .DEPTH (SLD_FIFO_DEPTH)
   ) u_fifo (
      .clk_sys_in    (clk_sys_in),
      .rst_in        (rst_in),
      .in_valid_in   (shift_evt),
      .in_ready_out  (fifo_in_ready),
      .in_data_in    (snap_q),
      .out_valid_out (fifo_out_valid),
      .out_ready_in  (fifo_out_ready),
      .out_data_out  (fifo_out_data)
   );

   // Drain stalls while local logic holds updates back
   // Eight words absorb link edges while the drain is held; a ninth is lost
   assign fifo_out_ready = ~update_hold_in;

   logic [15:0] shadow_q;      // System-side image of the shift stages
   logic        busy_q;        // Buffer full, next snapshot would be lost
   logic        overrun_q;     // Sticky: a snapshot was dropped

   // Shadow follows the buffered snapshots in order
   // Reset image matches the reset stages, so the latch starts coherent
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         shadow_q <= SLD_WORD_RST;
      end else if (fifo_out_valid && fifo_out_ready) begin
         shadow_q <= fifo_out_data;
      end
   end

   // The host cannot be stalled, so a full buffer is reported, not hidden
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         busy_q    <= 1'b0;
         overrun_q <= 1'b0;
      end else begin
         busy_q <= ~fifo_in_ready;
         if (shift_evt && !fifo_in_ready) begin
            overrun_q <= 1'b1;
         end
      end
   end

   assign busy_out    = busy_q;
   assign overrun_out = overrun_q;

   ////////////////////////////////////////////////////////////////////////////
   // Control pins: two-flop synchronisers, then pull resolution

   logic strobe_s1_q;          // Strobe level, first flop
   logic strobe_s2_q;          // Strobe level, second flop
   logic strobe_drv_s1_q;      // Strobe driven flag, first flop
   logic strobe_drv_s2_q;      // Strobe driven flag, second flop
   logic en_n_s1_q;            // Enable level, first flop
   logic en_n_s2_q;            // Enable level, second flop
   logic en_n_drv_s1_q;        // Enable driven flag, first flop
   logic en_n_drv_s2_q;        // Enable driven flag, second flop
   logic strobe_eff;           // Strobe after pull resolution, usable
   logic en_n_eff;             // Enable after pull resolution, usable

   // Every raw pin passes two flops before any gate sees it; the driven
   // flags reset low so the pull levels rule until the pins have settled
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         strobe_s1_q     <= SLD_STROBE_PULL;
         strobe_s2_q     <= SLD_STROBE_PULL;
         strobe_drv_s1_q <= 1'b0;
         strobe_drv_s2_q <= 1'b0;
         en_n_s1_q       <= SLD_EN_N_PULL;
         en_n_s2_q       <= SLD_EN_N_PULL;
         en_n_drv_s1_q   <= 1'b0;
         en_n_drv_s2_q   <= 1'b0;
      end else begin
         strobe_s1_q     <= latch_strobe_in;
         strobe_s2_q     <= strobe_s1_q;
         strobe_drv_s1_q <= latch_strobe_driven_in;
         strobe_drv_s2_q <= strobe_drv_s1_q;
         en_n_s1_q       <= out_en_n_in;
         en_n_s2_q       <= en_n_s1_q;
         en_n_drv_s1_q   <= out_en_n_driven_in;
         en_n_drv_s2_q   <= en_n_drv_s1_q;
      end
   end

   // An undriven pin takes its pull level
   assign strobe_eff = strobe_drv_s2_q ? strobe_s2_q : SLD_STROBE_PULL;
   assign en_n_eff   = en_n_drv_s2_q ? en_n_s2_q : SLD_EN_N_PULL;

   ////////////////////////////////////////////////////////////////////////////
   // Output latch and sink drive

   logic [15:0] latch_q;       // Output latch
   logic [15:0] sinks_q;       // Registered sink drive, 1 = sinking

   // Transparent while strobe high, frozen once it falls
   // Trade-off: transparency lags by a few system cycles, but every flop
   // stays on one clock and the latch never passes a half-shifted word
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         latch_q <= SLD_WORD_RST;
      end else if (strobe_eff) begin
         latch_q <= shadow_q;
      end
   end

   // Blanking gates the drive only; latch and shift contents stay
   // Registered, so the sink drive never glitches when the enable moves
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         sinks_q <= SLD_SINKS_OFF;
      end else if (en_n_eff) begin
         sinks_q <= SLD_SINKS_OFF;
      end else begin
         sinks_q <= latch_q;
      end
   end

   assign sink_channels_out = sinks_q;

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   // Past-valid helpers keep the first cycle after reset out of $past
   logic sys_seen_q;
   logic lnk_seen_q;

   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         sys_seen_q <= 1'b0;
      end else begin
         sys_seen_q <= 1'b1;
      end
   end

   always_ff @(posedge shift_clk_in or posedge rst_in) begin
      if (rst_in) begin
         lnk_seen_q <= 1'b0;
      end else begin
         lnk_seen_q <= 1'b1;
      end
   end

   // Link-domain checks, sampled on the host's clock
   chk_shift_move: assert property (@(posedge shift_clk_in) disable iff (rst_in)
      lnk_seen_q |-> shift_q == {$past(shift_q[14:0]), $past(serial_in)})
      else $error("shift register did not move by one");

   chk_serial_cascade: assert property (@(posedge shift_clk_in) disable iff (rst_in)
      lnk_seen_q |-> serial_out_out == $past(shift_q[14]))
      else $error("serial output is not the shifted last stage");

   chk_channel_order: assert property (@(posedge shift_clk_in) disable iff (rst_in)
      lnk_seen_q ##15 1'b1 |-> serial_out_out == $past(serial_in, 16))
      else $error("serial output is not the bit from sixteen edges ago");

   // System-domain checks
   chk_latch_follow: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      sys_seen_q && strobe_eff |=> latch_q == $past(shadow_q))
      else $error("latch does not follow shadow while strobe high");

   chk_latch_freeze: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      $fell(strobe_eff) ##0 !strobe_eff [*3] |-> $stable(latch_q))
      else $error("latch changed while strobe low");

   chk_sink_drive: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      !en_n_eff |=> sink_channels_out == $past(latch_q))
      else $error("enabled sinks do not match latch");

   chk_sink_map: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      !out_en_n_in && out_en_n_driven_in ##2 !en_n_eff
      |=> (sink_channels_out & ~$past(latch_q)) == 16'h0000)
      else $error("a sink is on with its latch bit clear");

   chk_sink_blank: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      en_n_eff |=> sink_channels_out == SLD_SINKS_OFF && ($stable(latch_q) || $past(strobe_eff)))
      else $error("sinks not blanked while enable high");

   chk_strobe_pull: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      !latch_strobe_driven_in [*3] |-> !strobe_eff)
      else $error("undriven strobe not read as low");

   chk_enable_pull: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      !out_en_n_driven_in [*4] |-> sink_channels_out == SLD_SINKS_OFF)
      else $error("undriven enable did not blank the sinks");

   chk_one_lights: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      !en_n_eff && latch_q[0] |=> sink_channels_out[0])
      else $error("latched one did not turn its sink on");

   chk_latch_hold: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      sys_seen_q && !strobe_eff |=> $stable(latch_q))
      else $error("latch moved while strobe low");

   chk_shadow_track: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      fifo_out_valid && !update_hold_in |=> shadow_q == $past(fifo_out_data))
      else $error("shadow missed a buffered snapshot");

endmodule

// ==== src/sld_pkg.sv ====
package sld_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Word layout
   localparam int          SLD_WORD_W      = 16;           // Shift stages and sink channels
   localparam int          SLD_LAST_STAGE  = 15;           // Stage that feeds the serial output
   localparam int          SLD_FIFO_DEPTH  = 8;            // Snapshot buffer depth in words

   ////////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic [15:0] SLD_WORD_RST    = 16'h0000;     // Shift, shadow and latch contents
   localparam logic [15:0] SLD_SINKS_OFF   = 16'h0000;     // All current sinks switched off
   localparam logic        SLD_STROBE_PULL = 1'b0;         // Level of an undriven latch strobe
   localparam logic        SLD_EN_N_PULL   = 1'b1;         // Level of an undriven enable

   ////////////////////////////////////////////////////////////////////////////
   // Timing figures
   localparam int          SLD_SYS_CLK_MHZ   = 250;        // System clock rate
   localparam int          SLD_SHIFT_MAX_MHZ = 30;         // Fastest shift clock the host may use
   localparam int          SLD_SYNC_STAGES   = 2;          // Flops in each synchroniser

endpackage

// ==== src/sld_fifo.sv ====
`timescale 1ns/1ns

// Small synchronous FIFO with valid/ready on both sides
module sld_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input  wire logic             clk_sys_in,
   input  wire logic             rst_in,
   // Fill side
   input  wire logic             in_valid_in,
   output logic                  in_ready_out,
   input  wire logic [WIDTH-1:0] in_data_in,
   // Drain side
   output logic                  out_valid_out,
   input  wire logic             out_ready_in,
   output logic      [WIDTH-1:0] out_data_out
);

   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];     // Storage array
   logic [AW-1:0]    wr_ptr_q;          // Next slot to write
   logic [AW-1:0]    rd_ptr_q;          // Next slot to read
   logic [AW:0]      count_q;           // Words held
   logic             push;              // Accepted write
   logic             pop;               // Accepted read

   // Pointer advance with wrap at any depth
   function automatic logic [AW-1:0] sld_next_ptr(input logic [AW-1:0] p);
      if (p == AW'(DEPTH - 1)) begin
         return '0;
      end
      return p + AW'(1);
   endfunction

   assign in_ready_out  = (count_q != (AW + 1)'(DEPTH));
   assign out_valid_out = (count_q != '0);
   assign out_data_out  = mem_q[rd_ptr_q];
   assign push          = in_valid_in && in_ready_out;
   assign pop           = out_valid_out && out_ready_in;

   ////////////////////////////////////////////////////////////////////////////
   // Storage write; no reset needed, count guards every read
   always_ff @(posedge clk_sys_in) begin
      if (push) begin
         mem_q[wr_ptr_q] <= in_data_in;
      end
   end

   // Pointers and fill count
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q  <= '0;
      end else begin
         if (push) begin
            wr_ptr_q <= sld_next_ptr(wr_ptr_q);
         end
         if (pop) begin
            rd_ptr_q <= sld_next_ptr(rd_ptr_q);
         end
         count_q <= count_q + (AW + 1)'(push) - (AW + 1)'(pop);
      end
   end

endmodule

// ==== test/sld_host_model.sv ====
`timescale 1ns/1ns
////////////////////////////////////////////////////////////
// Host end of the serial link; its clock runs only inside a frame
module sld_host_model
   import sld_pkg::*;
#(
   parameter int HALF_LO = 62,         // Low phase of the shift clock
   parameter int HALF_HI = 63          // High phase, 125 ns period in all
) (
   // Link pins toward the driver
   output logic      shift_clk_out,
   output logic      serial_data_out,
   // Chained data coming back from the last stage
   input  wire logic serial_back_in
);
   // Clock parked low, data parked at a defined level
   initial begin
      shift_clk_out   = 1'b0;
      serial_data_out = 1'b0;
   end

   localparam int HOLD_NS = 2;         // Data kept this long past the rising edge

   // One bit per rising edge; the returned bit is what the driver
   // showed just before that edge
   task automatic send_bit(input logic b, output logic back);
      serial_data_out = b;
      #HALF_LO;
      back = serial_back_in;
      shift_clk_out = 1'b1;            // 8 MHz, well below the limit
      #HOLD_NS;
      // Data now stale: invert it so nobody can rely on the old bit; done in
      // the high phase so the next bit never lands in the same time step
      serial_data_out = ~b;
      #(HALF_HI - HOLD_NS);
      shift_clk_out = 1'b0;
   endtask
endmodule

// ==== test/tb_top.sv ====
`timescale 1ns/1ns
////////////////////////////////////////////////////////////
// Self-checking bench of the serial-in parallel sink latch
module tb_top
   import sld_pkg::*;
;
   logic        clk_sys, rst, shift_clk, serial_data, serial_back;
   logic        strobe, strobe_drv, en_n, en_n_drv, hold, busy, overrun;
   logic [15:0] sinks;
   int          n_mismatch, n_tests;

   // System clock, 4 ns period
   initial clk_sys = 1'b0;
   always #2 clk_sys = ~clk_sys;

   sld_latch_driver i_dut (
      .clk_sys_in(clk_sys), .rst_in(rst), .shift_clk_in(shift_clk),
      .serial_in(serial_data), .serial_out_out(serial_back),
      .latch_strobe_in(strobe), .latch_strobe_driven_in(strobe_drv),
      .out_en_n_in(en_n), .out_en_n_driven_in(en_n_drv),
      .update_hold_in(hold), .sink_channels_out(sinks),
      .busy_out(busy), .overrun_out(overrun));

   sld_host_model i_host (
      .shift_clk_out(shift_clk), .serial_data_out(serial_data),
      .serial_back_in(serial_back));

   ////////////////////////////////////////////////////////////
   // Shared helpers
   task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
      n_tests++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   task automatic wait_sys(input int n);
      repeat (n) @(negedge clk_sys);
   endtask

   // Control pins change on a falling edge, then let the syncs settle
   task automatic pins(input logic s, input logic sd, input logic e, input logic ed);
      @(negedge clk_sys);
      strobe     = s;
      strobe_drv = sd;
      en_n       = e;
      en_n_drv   = ed;
      wait_sys(8);
   endtask

   // Whole word, channel 15 first; returns the word pushed out behind it
   task automatic send_word(input logic [15:0] w, output logic [15:0] back);
      logic b;
      for (int i = 15; i >= 0; i--) begin
         i_host.send_bit(w[i], b);
         back = {back[14:0], b};
      end
      wait_sys(40);                    // Crossing plus queue, well over 7 cycles
   endtask

   ////////////////////////////////////////////////////////////
   // Scenarios
   task automatic t_transparent();
      logic [15:0] words [4] = '{16'h8001, 16'h0000, 16'hFFFF, 16'h5A3C};
      logic [15:0] back;
      pins(1'b1, 1'b1, 1'b0, 1'b1);
      foreach (words[i]) begin
         send_word(words[i], back);
         check(sinks, words[i], "follow");
         check({15'h0, serial_back}, {15'h0, words[i][15]}, "last stage");
         if (i > 0) check(back, words[i-1], "chain");
      end
   endtask

   task automatic t_freeze_blank();
      logic [15:0] back;
      pins(1'b0, 1'b1, 1'b0, 1'b1);
      send_word(16'h1234, back);
      check(sinks, 16'h5A3C, "frozen");
      pins(1'b1, 1'b1, 1'b0, 1'b1);
      check(sinks, 16'h1234, "reopened");
      pins(1'b1, 1'b1, 1'b1, 1'b1);
      check(sinks, SLD_SINKS_OFF, "blank");
      send_word(16'h00F0, back);
      check(sinks, SLD_SINKS_OFF, "blank shift");
      pins(1'b1, 1'b1, 1'b0, 1'b1);
      check(sinks, 16'h00F0, "kept");
   endtask

   // Floating pins take their pull levels
   task automatic t_pulls();
      logic [15:0] back;
      pins(1'b1, 1'b0, 1'b0, 1'b1);
      send_word(16'hBEEF, back);
      check(sinks, 16'h00F0, "strobe float");
      pins(1'b1, 1'b0, 1'b0, 1'b0);
      check(sinks, SLD_SINKS_OFF, "enable float");
      pins(1'b1, 1'b1, 1'b0, 1'b1);
      check(sinks, 16'hBEEF, "driven again");
   endtask

   // Held drain: 8 snapshots fill the buffer, the 9th is lost
   task automatic t_overrun();
      logic b;
      @(negedge clk_sys);
      hold = 1'b1;
      repeat (SLD_FIFO_DEPTH) i_host.send_bit(1'b1, b);
      wait_sys(10);
      check({14'h0, busy, overrun}, 16'h0002, "full");
      i_host.send_bit(1'b1, b);
      wait_sys(10);
      check({14'h0, busy, overrun}, 16'h0003, "dropped");
      hold = 1'b0;
      wait_sys(20);
      check({14'h0, busy, overrun}, 16'h0001, "drained");
   endtask

   ////////////////////////////////////////////////////////////
   // Verdict, reached from the main sequence or the watchdog
   task automatic results();
      if (n_mismatch == 0 && n_tests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // Tests need about 17 us; cut a hang well after that
   initial begin
      #200000;
      n_mismatch++;
      results();
   end

   // Main sequence
   initial begin
      n_mismatch = 0;
      n_tests    = 0;
      rst        = 1'b1;
      strobe     = 1'b0;
      strobe_drv = 1'b1;
      en_n       = 1'b1;
      en_n_drv   = 1'b1;
      hold       = 1'b0;
      repeat (16) @(negedge clk_sys);
      check(sinks, SLD_SINKS_OFF, "reset sinks");
      check({13'h0, serial_back, busy, overrun}, 16'h0000, "reset flags");
      rst = 1'b0;
      wait_sys(4);
      t_transparent();
      t_freeze_blank();
      t_pulls();
      t_overrun();
      results();
   end
endmodule
